// ### verilog/hpm_regs.vh
/*
 * hpm_regs.vh - constants for the host port mode and dma counter block:
 * register addresses on the host port, field positions, reset values.
 * assumes it is included by bare name from the design files.
 */
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef HPM_REGS_VH
`define HPM_REGS_VH

// host port addresses (three address lines)
`define HPM_ADDR_ICR      3'h0
`define HPM_ADDR_CVR      3'h1
`define HPM_ADDR_ISR      3'h2
`define HPM_ADDR_HIGH     3'h5
`define HPM_ADDR_MID      3'h6
`define HPM_ADDR_LOW      3'h7

// control register fields
`define HPM_ICR_RXEN      0
`define HPM_ICR_TXEN      1
`define HPM_ICR_FLAG1     4
`define HPM_ICR_MODE_LO   5
`define HPM_ICR_MODE_HI   6
`define HPM_ICR_INIT      7

// command vector fields
`define HPM_CVR_REQ       7
`define HPM_CVR_VEC_RST   6'h12

// mode encodings
`define HPM_MODE_IRQ      2'h0
`define HPM_MODE_DMA24    2'h1
`define HPM_MODE_DMA16    2'h2
`define HPM_MODE_DMA8     2'h3

`endif

// ### verilog/hpm_sync.v
/*
 * hpm_sync.v - two-flop synchroniser for pins from the asynchronous host.
 * assumes a single processor clock; the first stage feeds only the second.
 */
`timescale 1ns/100ps

module hpm_sync #(
	parameter W = 1
) (
	// clock
	input  wire         clk,
	input  wire         ce,
	// data
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta_reg;

	// no reset: pure metastability filter
	always @(posedge clk) begin
		if (ce) begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // hpm_sync

// ### verilog/hpm_counter.v
/*
 * hpm_counter.v - dma byte address counter.
 * assumes step and load are one-cycle pulses in the processor clock domain.
 */
`timescale 1ns/100ps
`include "hpm_regs.vh"

module hpm_counter (
	// clock and reset
	input  wire       clk,
	input  wire       ce,
	input  wire       reset_n,
	// control
	input  wire [1:0] mode,
	input  wire       load,
	input  wire [1:0] load_val,
	input  wire       step,
	// state
	output reg  [1:0] count,
	output reg        word_done
);
	// step reloads the mode after the low byte, so 8/16/24 bit words circle
	always @(posedge clk) begin
		if (!reset_n) begin
			count     <= 2'h0;
			word_done <= 1'b0;
		end else if (ce) begin
			word_done <= 1'b0;
			if (load)
				count <= load_val;
			else if (step) begin
				if (count == 2'h3) begin
					count     <= mode;
					word_done <= 1'b1;
				end else
					count <= count + 2'h1;
			end
		end
	end
endmodule // hpm_counter

// ### verilog/hpm_port.v
/*
 * hpm_port.v - host side of a byte-wide parallel host port: mode and flag
 * control, initialise command, dma address counter and command vector.
 * assumes the host pins are asynchronous and pass two flops here; the
 * processor side supplies word-transfer events on the same clock.
 */
`timescale 1ns/100ps
`include "hpm_regs.vh"

module hpm_port (
	// clock and reset
	input  wire        clk,
	input  wire        ce,
	input  wire        reset_n,
	// host pins
	input  wire [2:0]  host_addr,
	input  wire        host_cs_n,
	input  wire        host_rd_n,
	input  wire        host_wr_n,
	input  wire        host_acknowledge_pin_n,
	input  wire [7:0]  host_data_in,
	output reg  [7:0]  host_data_out,
	output reg         host_data_oe,
	output reg         host_request_pin,
	// processor side events (same clock)
	input  wire        proc_rx_load,
	input  wire        proc_tx_taken,
	input  wire        proc_cmd_accept,
	input  wire [23:0] proc_rx_word,
	input  wire [7:0]  int_vector,
	// processor side view
	output reg         host_flag_one,
	output reg         processor_transmit_empty,
	output reg         processor_receive_full,
	output reg  [23:0] proc_tx_word,
	output reg         proc_word_irq,
	output reg         command_pending,
	output reg  [6:0]  command_address,
	output reg  [1:0]  dma_address
);
	//------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------
	wire [2:0] addr_s;
	wire [7:0] data_s;
	wire       cs_s, rd_s, wr_s, ack_s;

	hpm_sync #(.W(15)) u_sync (
		.clk (clk),
		.ce  (ce),
		.d   ({host_addr, host_data_in, host_cs_n, host_rd_n, host_wr_n, host_acknowledge_pin_n}),
		.q   ({addr_s, data_s, cs_s, rd_s, wr_s, ack_s})
	);

	//------------------------------------------------------------
	// strobe edges
	//------------------------------------------------------------
	reg  rd_act_reg, wr_act_reg, ack_act_reg;
	wire rd_act  = !cs_s && !rd_s;
	wire wr_act  = !cs_s && !wr_s;
	wire ack_act = !ack_s;
	wire wr_edge  = wr_act && !wr_act_reg;     // write taken on leading edge
	wire rd_end   = !rd_act && rd_act_reg;     // read side effects on trailing edge
	wire ack_end  = !ack_act && ack_act_reg;   // dma byte completes on release

	always @(posedge clk) begin
		if (!reset_n) begin
			rd_act_reg  <= 1'b0;
			wr_act_reg  <= 1'b0;
			ack_act_reg <= 1'b0;
		end else if (ce) begin
			rd_act_reg  <= rd_act;
			wr_act_reg  <= wr_act;
			ack_act_reg <= ack_act;
		end
	end

	//------------------------------------------------------------
	// registers and state
	//------------------------------------------------------------
	reg        rx_en_reg, tx_en_reg, init_reg;
	reg [1:0]  mode_reg;
	reg [5:0]  vec_reg;
	reg        creq_reg;
	reg        rx_full_reg, tx_empty_reg;
	reg [23:0] rx_bytes_reg, tx_bytes_reg;

	wire       dma_on = mode_reg != `HPM_MODE_IRQ;
	wire [1:0] count;
	wire       word_done;

	// during dma the counter stands in for the low address lines
	wire       dma_byte = dma_on && ack_act;
	wire [2:0] sel_addr = dma_byte ? {1'b1, count} : addr_s;
	wire       dma_rd   = dma_on && rx_en_reg && !tx_en_reg;
	wire       dma_wr   = dma_on && tx_en_reg && !rx_en_reg;
	wire       dma_step = dma_on && ack_end;

	// init waits for an active dma acknowledge to finish
	wire       init_go  = init_reg && !(dma_on && ack_act) && !dma_step;
	wire [1:0] init_cnt = dma_on ? mode_reg : 2'h0;

	wire       host_wr   = wr_edge;
	wire       dma_wr_ev = dma_wr && ack_act && !ack_act_reg;
	wire       wr_ev     = host_wr || dma_wr_ev;
	wire [2:0] wr_addr   = dma_wr_ev ? {1'b1, count} : addr_s;
	wire       low_read  = (rd_end && addr_s == `HPM_ADDR_LOW)
	                       || (dma_rd && ack_end && count == 2'h3);
	wire       low_write = wr_ev && wr_addr == `HPM_ADDR_LOW;

	hpm_counter u_cnt (
		.clk       (clk),
		.ce        (ce),
		.reset_n   (reset_n),
		.mode      (mode_reg),
		.load      (init_go),
		.load_val  (init_cnt),
		.step      (dma_step),
		.count     (count),
		.word_done (word_done)
	);

	// control register: host only, the processor has no write path
	always @(posedge clk) begin
		if (!reset_n) begin
			rx_en_reg <= 1'b0;
			tx_en_reg <= 1'b0;
			host_flag_one <= 1'b0;
			mode_reg  <= `HPM_MODE_IRQ;
			init_reg  <= 1'b0;
		end else if (ce) begin
			if (host_wr && addr_s == `HPM_ADDR_ICR) begin
				rx_en_reg     <= data_s[`HPM_ICR_RXEN];
				tx_en_reg     <= data_s[`HPM_ICR_TXEN];
				host_flag_one <= data_s[`HPM_ICR_FLAG1];
				mode_reg      <= {data_s[`HPM_ICR_MODE_HI], data_s[`HPM_ICR_MODE_LO]};
				init_reg      <= data_s[`HPM_ICR_INIT] | (init_reg & !init_go);
			end else if (init_go)
				init_reg <= 1'b0;
		end
	end

	// command vector: vector and request in one write; accept clears request
	always @(posedge clk) begin
		if (!reset_n) begin
			vec_reg  <= `HPM_CVR_VEC_RST;
			creq_reg <= 1'b0;
		end else if (ce) begin
			if (host_wr && addr_s == `HPM_ADDR_CVR) begin
				vec_reg  <= data_s[5:0];
				creq_reg <= data_s[`HPM_CVR_REQ];
			end else if (proc_cmd_accept)
				creq_reg <= 1'b0;
		end
	end

	// status flags; set wins over clear in the same cycle, except low_read setting processor_transmit_empty, which proc_rx_load overrides
	always @(posedge clk) begin
		if (!reset_n) begin
			rx_full_reg              <= 1'b0;
			tx_empty_reg             <= 1'b1;
			processor_transmit_empty <= 1'b1;
			processor_receive_full   <= 1'b0;
		end else if (ce) begin
			if (proc_rx_load)
				rx_full_reg <= 1'b1;
			else if (low_read || (init_go && rx_en_reg))
				rx_full_reg <= 1'b0;
			if (proc_tx_taken)
				tx_empty_reg <= 1'b1;
			else if (init_go && tx_en_reg)
				tx_empty_reg <= 1'b1;
			else if (low_write)
				tx_empty_reg <= 1'b0;
			if (init_go && rx_en_reg)
				processor_transmit_empty <= 1'b1;
			else if (proc_rx_load)
				processor_transmit_empty <= 1'b0;
			else if (low_read)
				processor_transmit_empty <= 1'b1;
			if (low_write)
				processor_receive_full <= 1'b1;
			else if (proc_tx_taken || (init_go && tx_en_reg))
				processor_receive_full <= 1'b0;
		end
	end

	// data bytes: receive loaded by processor, transmit by host or dma
	always @(posedge clk) begin
		if (!reset_n) begin
			rx_bytes_reg <= 24'h000000;
			tx_bytes_reg <= 24'h000000;
			proc_tx_word <= 24'h000000;
		end else if (ce) begin
			if (proc_rx_load)
				rx_bytes_reg <= proc_rx_word;
			if (wr_ev) begin
				case (wr_addr)
					`HPM_ADDR_HIGH: tx_bytes_reg[23:16] <= data_s;
					`HPM_ADDR_MID:  tx_bytes_reg[15:8]  <= data_s;
					`HPM_ADDR_LOW:  tx_bytes_reg[7:0]   <= data_s;
					default:        tx_bytes_reg        <= tx_bytes_reg;
				endcase
			end
			if (low_write)
				proc_tx_word <= {tx_bytes_reg[23:8], data_s};
		end
	end

	//------------------------------------------------------------
	// pin outputs
	//------------------------------------------------------------
	reg [7:0] rd_mux;
	always @* begin
		case (sel_addr)
			`HPM_ADDR_ICR:  rd_mux = {init_reg, mode_reg, host_flag_one, 2'h0, tx_en_reg, rx_en_reg};
			`HPM_ADDR_CVR:  rd_mux = {creq_reg, 1'b0, vec_reg};
			`HPM_ADDR_ISR:  rd_mux = {host_request_pin, dma_on, 4'h0, tx_empty_reg, rx_full_reg};
			`HPM_ADDR_HIGH: rd_mux = rx_bytes_reg[23:16];
			`HPM_ADDR_MID:  rd_mux = rx_bytes_reg[15:8];
			`HPM_ADDR_LOW:  rd_mux = rx_bytes_reg[7:0];
			default:        rd_mux = 8'h00;
		endcase
	end

	// request pin, bus drive, processor word event
	always @(posedge clk) begin
		if (!reset_n) begin
			host_request_pin <= 1'b0;
			host_data_out    <= 8'h00;
			host_data_oe     <= 1'b0;
			proc_word_irq    <= 1'b0;
			command_pending  <= 1'b0;
			command_address  <= 7'h00;
			dma_address      <= 2'h0;
		end else if (ce) begin
			host_request_pin <= (rx_en_reg && rx_full_reg) || (tx_en_reg && tx_empty_reg);
			if (!dma_on && ack_act && host_request_pin) begin
				host_data_out <= int_vector;
				host_data_oe  <= 1'b1;
			end else if (dma_byte && dma_rd) begin
				host_data_out <= rd_mux;
				host_data_oe  <= 1'b1;
			end else if (!dma_byte && rd_act) begin
				host_data_out <= rd_mux;
				host_data_oe  <= 1'b1;
			end else begin
				host_data_out <= 8'h00;
				host_data_oe  <= 1'b0;
			end
			proc_word_irq   <= dma_on && word_done;
			command_pending <= creq_reg;
			command_address <= {vec_reg, 1'b0};
			dma_address     <= count;
		end
	end
endmodule // hpm_port

// ### tb/hpm_port_sva.sv
/* hpm_port_sva.sv - assertions on the ports of the host port block.
 * assumes one clock, ce held high and a synchronous active-low reset. */
`timescale 1ns/100ps
//----------------------------------------
// checker
//----------------------------------------
module hpm_port_sva (
	// clock and reset
	input wire       clk,
	input wire       reset_n,
	// host pins
	input wire       host_rd_n,
	input wire       host_wr_n,
	input wire       host_acknowledge_pin_n,
	input wire       host_data_oe,
	input wire       host_request_pin,
	// processor side
	input wire       proc_cmd_accept,
	input wire       proc_tx_taken,
	input wire       host_flag_one,
	input wire       processor_transmit_empty,
	input wire       processor_receive_full,
	input wire       proc_word_irq,
	input wire       command_pending,
	input wire [6:0] command_address
);
	// no disable here: this one watches the reset itself
	property p_rst;
		@(posedge clk) !reset_n |=> !host_request_pin && !host_data_oe && !host_flag_one
			&& !command_pending && processor_transmit_empty;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_vec;
		@(posedge clk) disable iff (!reset_n) !command_address[0];
	endproperty
	a_vec: assert property (p_vec) else $error("routine address not twice vector");
	// strobes are held at least three cycles, so three back still shows the cause
	property p_oe_on;
		@(posedge clk) disable iff (!reset_n) $rose(host_data_oe) |->
			$past(!host_rd_n, 3) || $past(!host_acknowledge_pin_n, 3);
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("bus driven without strobe");
	property p_oe_off;
		@(posedge clk) disable iff (!reset_n) $fell(host_data_oe) |->
			$past(host_rd_n, 3) && $past(host_acknowledge_pin_n, 3);
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus dropped under strobe");
	property p_flag;
		@(posedge clk) disable iff (!reset_n) $changed(host_flag_one) |-> $past(!host_wr_n, 3);
	endproperty
	a_flag: assert property (p_flag) else $error("flag moved without host write");
	property p_irq;
		@(posedge clk) disable iff (!reset_n) proc_word_irq |=> !proc_word_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("word interrupt longer than a cycle");
	property p_cmd;
		@(posedge clk) disable iff (!reset_n) proc_cmd_accept |-> ##2 !command_pending;
	endproperty
	a_cmd: assert property (p_cmd) else $error("command request not cleared");
	property p_taken;
		@(posedge clk) disable iff (!reset_n) proc_tx_taken ##1 1'b1 |-> !processor_receive_full;
	endproperty
	a_taken: assert property (p_taken) else $error("receive full kept after take");
endmodule // hpm_port_sva

bind hpm_port hpm_port_sva u_sva (.clk(clk), .reset_n(reset_n), .host_rd_n(host_rd_n),
	.host_wr_n(host_wr_n), .host_acknowledge_pin_n(host_acknowledge_pin_n),
	.host_data_oe(host_data_oe), .host_request_pin(host_request_pin),
	.proc_cmd_accept(proc_cmd_accept), .proc_tx_taken(proc_tx_taken),
	.host_flag_one(host_flag_one), .processor_transmit_empty(processor_transmit_empty),
	.processor_receive_full(processor_receive_full), .proc_word_irq(proc_word_irq),
	.command_pending(command_pending), .command_address(command_address));

// ### tb/hpm_dma_host.sv
/* hpm_dma_host.sv - far-side dma controller model.
 * assumes the bench puts dout on the data pins while drive is high. */
`timescale 1ns/100ps
module hpm_dma_host (
	// clock and control
	input  wire        clk,
	input  wire        go,
	input  wire        tx,
	input  wire [1:0]  nb,
	// port pins
	input  wire        req,
	input  wire [7:0]  din,
	input  wire        oe,
	output reg         ack_n,
	output reg         drive,
	output reg  [7:0]  dout,
	// results
	output reg  [1:0]  cnt,
	output reg  [23:0] cap
);
	reg [2:0] t;
	initial begin
		{ack_n, drive, dout, cnt, cap, t} = {1'b1, 38'h0};
	end
	// one acknowledge per byte, five low and seven high; no address is driven
	always @(posedge clk) begin
		if (!go) begin
			{ack_n, drive, cnt, cap, t} <= {1'b1, 30'h0};
		end else if (ack_n) begin
			if (t != 3'h0)
				t <= t - 3'h1;
			else if (req && cnt != nb) begin
				ack_n <= 1'b0;
				drive <= tx;
				dout  <= 8'h30 + {6'h0, cnt};
				t     <= 3'h4;
			end
		end else if (t != 3'h0)
			t <= t - 3'h1;
		else begin
			// released line shows the inverse so a stale byte cannot pass
			{ack_n, drive, dout, t} <= {1'b1, 1'b0, ~dout, 3'h6};
			cnt <= cnt + 2'h1;
			if (oe)
				cap <= {cap[15:0], din};
		end
	end
endmodule // hpm_dma_host

// ### tb/host_port_mode_and_dma_counter_tb.sv
/* host_port_mode_and_dma_counter_tb.sv - self-checking bench for hpm_port.
 * assumes ce held high and int_vector fixed; the dma model answers requests. */
`timescale 1ns/100ps
module host_port_mode_and_dma_counter_tb;
	reg         clk = 0, reset_n = 0, cs_n = 1, rd_n = 1, wr_n = 1, go = 0, tx = 0;
	reg         rx_load = 0, tx_taken = 0, cmd_acc = 0;
	reg  [2:0]  addr = 0;
	reg  [7:0]  wdata = 0, rv;
	reg  [23:0] rx_word = 0;
	reg  [1:0]  nb = 0;
	wire [7:0]  dout, pd;
	wire        oe, req, ack_n, pdrv, flag1, pte, prf, wirq, cpend;
	wire [23:0] tx_word, cap;
	wire [6:0]  caddr;
	wire [1:0]  daddr, pcnt;
	integer     n_mismatch = 0, compares = 0, cyc = 0, nirq = 0, m, i0, k;
	initial forever #50 clk = ~clk;
	// watchdog and word interrupt count
	always @(posedge clk) begin
		cyc <= cyc + 1;
		nirq <= nirq + (wirq === 1'b1);
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			conclude;
		end
	end
	hpm_port dut (.clk(clk), .ce(1'b1), .reset_n(reset_n), .host_addr(addr), .host_cs_n(cs_n),
		.host_rd_n(rd_n), .host_wr_n(wr_n), .host_acknowledge_pin_n(ack_n),
		.host_data_in(pdrv ? pd : wdata), .host_data_out(dout), .host_data_oe(oe),
		.host_request_pin(req), .proc_rx_load(rx_load), .proc_tx_taken(tx_taken),
		.proc_cmd_accept(cmd_acc), .proc_rx_word(rx_word), .int_vector(8'h5a),
		.host_flag_one(flag1), .processor_transmit_empty(pte), .processor_receive_full(prf),
		.proc_tx_word(tx_word), .proc_word_irq(wirq), .command_pending(cpend),
		.command_address(caddr), .dma_address(daddr));
	hpm_dma_host u_host (.clk(clk), .go(go), .tx(tx), .nb(nb), .req(req), .din(dout), .oe(oe),
		.ack_n(ack_n), .drive(pdrv), .dout(pd), .cnt(pcnt), .cap(cap));
	//----------------------------------------
	// shared tasks
	//----------------------------------------
	task wt(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input string nm, input [23:0] e, input [23:0] g);
		begin
			compares = compares + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("ERROR %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// write strobe held four cycles low, read strobe seven, both six high, above the three-cycle minimum
	task hwr(input [2:0] a, input [7:0] d);
		begin
			{addr, wdata, cs_n, wr_n} <= {a, d, 2'b00};
			wt(4);
			{cs_n, wr_n} <= 2'b11;
			wt(6);
		end
	endtask
	task hrd(input [2:0] a);
		begin
			{addr, cs_n, rd_n} <= {a, 2'b00};
			wt(6);
			#1 rv = oe ? dout : 8'hxx;
			@(posedge clk) {cs_n, rd_n} <= 2'b11;
			wt(6);
		end
	endtask
	task pulse_rx(input [23:0] w);
		begin
			@(posedge clk) {rx_word, rx_load} <= {w, 1'b1};
			@(posedge clk) rx_load <= 1'b0;
			wt(2);
		end
	endtask
	task conclude;
		begin
			$display("compares %0d n_mismatch %0d", compares, n_mismatch);
			if (n_mismatch == 0 && compares > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	//----------------------------------------
	// scenarios
	//----------------------------------------
	task t_reset;
		begin
			hrd(0); chk("ctrl", 0, rv);
			hrd(1); chk("vector", 8'h12, rv);
			chk("cmd_addr", 7'h24, caddr);
			hrd(2); chk("status", 8'h02, rv);
			hrd(3); chk("unmapped", 0, rv);
			hwr(0, 8'h10); chk("flag", 1, flag1);
			hwr(0, 8'h00); chk("flag", 0, flag1);
			hwr(1, 8'hbf); chk("pending", 1, cpend); chk("cmd_addr", 7'h7e, caddr);
			@(posedge clk) cmd_acc <= 1'b1;
			@(posedge clk) cmd_acc <= 1'b0;
			hrd(1); chk("vector", 8'h3f, rv);
			$display("t_reset done");
		end
	endtask
	task t_irq;
		begin
			pulse_rx(24'habcdef);
			hwr(0, 8'h01); chk("req", 1, req);
			hrd(5); chk("rx_high", 8'hab, rv);
			hrd(6); chk("rx_mid", 8'hcd, rv);
			hrd(7); chk("rx_low", 8'hef, rv); chk("req", 0, req);
			hwr(0, 8'h02); chk("req", 1, req);
			hwr(5, 8'h12); hwr(6, 8'h34); hwr(7, 8'h56);
			chk("tx_word", 24'h123456, tx_word); chk("req", 0, req);
			@(posedge clk) tx_taken <= 1'b1;
			@(posedge clk) tx_taken <= 1'b0;
			wt(4); chk("req", 1, req);
			@(posedge clk) {nb, tx, go} <= {2'h1, 2'b01};
			wt(20);
			chk("int_vector", 8'h5a, cap[7:0]);
			@(posedge clk) go <= 1'b0;
			pulse_rx(24'h000001);
			hwr(0, 8'h81); hrd(0); chk("ctrl", 8'h01, rv);
			chk("dma_addr", 0, daddr); chk("proc_te", 1, pte);
			hrd(2); chk("status", 8'h02, rv);
			$display("t_irq done");
		end
	endtask
	task t_dma;
		begin
			for (m = 1; m < 4; m = m + 1) begin
				hwr(0, 8'h81 | (m << 5)); chk("dma_addr", m, daddr);
				pulse_rx(24'ha1b2c3);
				i0 = nirq;
				@(posedge clk) {nb, tx, go} <= {4 - m, 2'b01};
				for (k = 0; k < 300 && pcnt !== nb; k = k + 1) @(posedge clk);
				wt(8);
				chk("dma_rx", 24'ha1b2c3 & (24'hffffff >> (8 * (m - 1))), cap);
				chk("word_irq", 1, nirq - i0);
				chk("dma_addr", m, daddr);
				@(posedge clk) go <= 1'b0;
			end
			hwr(0, 8'ha2);
			@(posedge clk) {nb, tx, go} <= {2'h3, 2'b11};
			for (k = 0; k < 300 && pcnt !== nb; k = k + 1) @(posedge clk);
			wt(8);
			chk("dma_tx", 24'h303132, tx_word);
			@(posedge clk) go <= 1'b0;
			$display("t_dma done");
		end
	endtask
	initial begin
		wt(4);
		reset_n <= 1'b1;
		wt(3);
		t_reset;
		t_irq;
		t_dma;
		conclude;
	end
endmodule // host_port_mode_and_dma_counter_tb
